// *** hw/cpk_pkg.sv ***
package cpk_pkg;
  localparam int unsigned CPK_WORD_W = 64;
  localparam int unsigned CPK_TYPE_W = 6;
  localparam int unsigned CPK_PIX_W  = 24;
  localparam int unsigned CPK_SLOTS  = 10;

  localparam logic [5:0] CPK_T_RGB444   = 6'h20;
  localparam logic [5:0] CPK_T_RGB555   = 6'h21;
  localparam logic [5:0] CPK_T_RGB565   = 6'h22;
  localparam logic [5:0] CPK_T_RGB666   = 6'h23;
  localparam logic [5:0] CPK_T_RGB888   = 6'h24;
  localparam logic [5:0] CPK_T_RAW6     = 6'h28;
  localparam logic [5:0] CPK_T_RAW7     = 6'h29;
  localparam logic [5:0] CPK_T_RAW8     = 6'h2A;
  localparam logic [5:0] CPK_T_RAW10    = 6'h2B;
  localparam logic [5:0] CPK_T_RAW12    = 6'h2C;
  localparam logic [5:0] CPK_T_RAW14    = 6'h2D;
  localparam logic [5:0] CPK_T_Y420_8   = 6'h18;
  localparam logic [5:0] CPK_T_Y420_10  = 6'h19;
  localparam logic [5:0] CPK_T_Y420_L8  = 6'h1A;
  localparam logic [5:0] CPK_T_Y420_8C  = 6'h1C;
  localparam logic [5:0] CPK_T_Y420_10C = 6'h1D;
  localparam logic [5:0] CPK_T_Y422_8   = 6'h1E;
  localparam logic [5:0] CPK_T_Y422_10  = 6'h1F;
  localparam logic [5:0] CPK_T_USER_LO  = 6'h30;
  localparam logic [5:0] CPK_T_USER_HI  = 6'h37;

  // up to ten pixel samples, slot 0 is pixel 1; yuv slots carry samples
  typedef struct packed {
    logic [CPK_SLOTS-1:0][CPK_PIX_W-1:0] pix;
  } cpk_pixels_t;

  typedef struct packed {
    logic vsync;
    logic hsync;
    logic valid;
  } cpk_sync_t;
endpackage

// *** hw/cpk_line_par.sv ***
module cpk_line_par
  import cpk_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // sync in
  input  wire logic vsync,
  input  wire logic hsync,
  // line parity, high on odd lines
  output logic      odd_line
);
  logic hs_q, hs_d, odd_q, odd_d;

  always_comb begin
    hs_d  = hsync;
    odd_d = odd_q;
    if (vsync) begin
      odd_d = 1'b1; // [R20]
    end else if (hs_q && !hsync) begin
      odd_d = ~odd_q; // [R20]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hs_q  <= 1'b0;
      odd_q <= 1'b1;
    end else begin
      hs_q  <= hs_d;
      odd_q <= odd_d;
    end
  end

  assign odd_line = odd_q;
endmodule

// *** hw/cpk_type_hold.sv ***
module cpk_type_hold
  import cpk_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // requested type and line state
  input  wire logic [CPK_TYPE_W-1:0] type_req,
  input  wire logic                  hsync,
  // type in force
  output logic [CPK_TYPE_W-1:0]      type_cur
);
  logic [CPK_TYPE_W-1:0] type_q, type_d;

  always_comb begin
    type_d = type_q;
    if (!hsync) begin
      type_d = type_req; // [R19]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      type_q <= CPK_T_RAW8;
    end else begin
      type_q <= type_d;
    end
  end

  assign type_cur = type_q;
endmodule

// *** hw/cpk_packer.sv ***
// Behaviour
// [R1] a new 64-bit word goes out every pixel clock during video
// [R2] the word layout follows the current video data type
// [R3] raw6: ten 6-bit pixels from bit 0, top bits zero
// [R4] raw7: eight 7-bit pixels from bit 0, rest zero
// [R5] raw8 and user 8-bit: eight bytes, pixel 1 lowest
// [R6] raw10: six 10-bit pixels, bits 63..60 zero
// [R7] raw12: five 12-bit pixels, bits 63..60 zero
// [R8] raw14: four 14-bit pixels from bit 0, rest zero
// [R9] rgb444: four 12-bit pixels, bits 63..48 zero
// [R10] rgb555: four 15-bit pixels, top four bits zero
// [R11] rgb565: four 16-bit pixels fill the word
// [R12] rgb666: three 18-bit pixels, rest zero
// [R13] rgb888: two 24-bit pixels, bits 63..48 zero
// [R14] yuv420 8-bit: odd lines eight Y, even lines U Y V Y order
// [R15] legacy yuv420: C1 Y1 Y2 C3 Y3 Y4, chroma U odd, V even
// [R16] yuv420 10-bit: odd six Y, even U1 Y1 V1 Y2, rest zero
// [R17] yuv422 8-bit: U1 Y1 V1 Y2 U3 Y3 V3 Y4 bytes
// [R18] yuv422 10-bit: U1 Y1 V1 Y2 samples, bits 63..40 zero
// [R19] type changes only take effect while hsync is low
// [R20] first line of a frame is odd; parity toggles per line
// [R21] device reads fields by width; padding content is ignored
module cpk_packer
  import cpk_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // user pixel side
  input  cpk_pkg::cpk_pixels_t       pix_in,
  input  cpk_pkg::cpk_sync_t         sync_in,
  input  wire logic [CPK_TYPE_W-1:0] type_req,
  // transmitter video side
  output logic [CPK_WORD_W-1:0]      tx_data,
  output logic [CPK_TYPE_W-1:0]      tx_type,
  output logic                       tx_hsync,
  output logic                       tx_vsync,
  output logic                       tx_valid
);
  import cpk_pkg::*;

  logic                  odd_line;
  logic [CPK_TYPE_W-1:0] type_cur;
  logic [CPK_WORD_W-1:0] data_q, data_d;
  logic [CPK_TYPE_W-1:0] type_q, type_d;
  cpk_sync_t             sync_q, sync_d;
  logic [CPK_WORD_W-1:0] w6, w7, w8, w10, w12, w14, w15, w16, w18, w24;
  logic [CPK_WORD_W-1:0] wy8e, wyl8, wy10e;

  cpk_line_par u_par (
    .clk      (clk),
    .rst      (rst),
    .vsync    (sync_in.vsync),
    .hsync    (sync_in.hsync),
    .odd_line (odd_line)
  );

  cpk_type_hold u_type (
    .clk      (clk),
    .rst      (rst),
    .type_req (type_req),
    .hsync    (sync_in.hsync),
    .type_cur (type_cur)
  );

  // per-slot field placement, pixel 1 lowest
  always_comb begin
    w6  = '0;
    w7  = '0;
    w8  = '0;
    w10 = '0;
    w12 = '0;
    w14 = '0;
    w15 = '0;
    w16 = '0;
    w18 = '0;
    w24 = '0;
    for (int i = 0; i < 10; i++) begin
      w6[i*6 +: 6] = pix_in.pix[i][5:0]; // [R3]
    end
    for (int i = 0; i < 8; i++) begin
      w7[i*7 +: 7] = pix_in.pix[i][6:0]; // [R4]
      w8[i*8 +: 8] = pix_in.pix[i][7:0]; // [R5]
    end
    for (int i = 0; i < 6; i++) begin
      w10[i*10 +: 10] = pix_in.pix[i][9:0]; // [R6]
    end
    for (int i = 0; i < 5; i++) begin
      w12[i*12 +: 12] = pix_in.pix[i][11:0]; // [R7]
    end
    for (int i = 0; i < 4; i++) begin
      w14[i*14 +: 14] = pix_in.pix[i][13:0]; // [R8]
      w15[i*15 +: 15] = pix_in.pix[i][14:0]; // [R10]
      w16[i*16 +: 16] = pix_in.pix[i][15:0]; // [R11]
    end
    for (int i = 0; i < 3; i++) begin
      w18[i*18 +: 18] = pix_in.pix[i][17:0]; // [R12]
    end
    for (int i = 0; i < 2; i++) begin
      w24[i*24 +: 24] = pix_in.pix[i]; // [R13]
    end
  end

  // yuv sample orders: slots carry samples in output order
  always_comb begin
    wy8e  = w8;  // [R14] [R17]
    wyl8  = {16'h0000, w8[47:0]}; // [R15]
    wy10e = {24'h000000, w10[39:0]}; // [R16] [R18]
  end

  always_comb begin
    sync_d = sync_in; // [R1]
    type_d = type_cur;
    data_d = '0;
    unique case (type_cur) // [R2]
      CPK_T_RAW6:    data_d = w6;
      CPK_T_RAW7:    data_d = w7;
      CPK_T_RAW8:    data_d = w8;
      CPK_T_RAW10:   data_d = w10;
      CPK_T_RAW12:   data_d = w12;
      CPK_T_RAW14:   data_d = w14;
      CPK_T_RGB444:  data_d = {16'h0000, w12[47:0]}; // [R9]
      CPK_T_RGB555:  data_d = w15;
      CPK_T_RGB565:  data_d = w16;
      CPK_T_RGB666:  data_d = w18;
      CPK_T_RGB888:  data_d = w24;
      CPK_T_Y420_8,
      CPK_T_Y420_8C: data_d = odd_line ? w8 : wy8e; // [R14] [R20]
      CPK_T_Y420_L8: data_d = wyl8;
      CPK_T_Y420_10,
      CPK_T_Y420_10C: data_d = odd_line ? w10 : wy10e; // [R16] [R20]
      CPK_T_Y422_8:  data_d = wy8e;
      CPK_T_Y422_10: data_d = wy10e;
      default: begin
        if (type_cur >= CPK_T_USER_LO && type_cur <= CPK_T_USER_HI) begin
          data_d = w8; // [R5]
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_q <= '0;
      type_q <= CPK_T_RAW8;
      sync_q <= '0;
    end else begin
      data_q <= data_d;
      type_q <= type_d;
      sync_q <= sync_d;
    end
  end

  assign tx_data  = data_q;
  assign tx_type  = type_q;
  assign tx_hsync = sync_q.hsync;
  assign tx_vsync = sync_q.vsync;
  assign tx_valid = sync_q.valid;
endmodule

// *** dv/cpk_dev_model.sv ***
// transmitter side: reads one field of the word by width and index
module cpk_dev_model (
  // word from the packer
  input  wire logic [63:0] tx_data,
  // field select
  input  wire logic [4:0]  width,
  input  wire logic [3:0]  idx,
  // field read back
  output logic      [23:0] field
);
  timeunit 1ns;
  timeprecision 1ps;
  assign field = 24'(tx_data >> (8'(width) * 8'(idx))) &
                 ((24'h1 << width) - 24'h1);
endmodule

// *** dv/cpk_monitor.sv ***
module cpk_monitor
  import cpk_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst,
  input cpk_pkg::cpk_pixels_t       pix_in,
  input cpk_pkg::cpk_sync_t         sync_in,
  input wire logic [CPK_WORD_W-1:0] tx_data,
  input wire logic [CPK_TYPE_W-1:0] tx_type,
  input wire logic                  tx_hsync,
  input wire logic                  tx_vsync,
  input wire logic                  tx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_sync_copy: assert property (!$past(rst) |-> tx_hsync ==
    $past(sync_in.hsync) && tx_valid == $past(sync_in.valid) &&
    tx_vsync == $past(sync_in.vsync)) else $error("sync");
  a_type_hold: assert property ($changed(tx_type) |->
    !$past(sync_in.hsync, 2)) else $error("type changed in line");
  a_raw8_pix: assert property (tx_type == CPK_T_RAW8 && !$past(rst) |->
    tx_data[15:8] == $past(pix_in.pix[1][7:0])) else $error("raw8 pixel");
  a_raw6_pad: assert property (tx_type == CPK_T_RAW6 |->
    tx_data[63:60] == 4'h0) else $error("raw6 pad");
  a_raw7_pad: assert property (tx_type == CPK_T_RAW7 |->
    tx_data[63:56] == 8'h0) else $error("raw7 pad");
  a_raw10_pad: assert property (tx_type == CPK_T_RAW10 |->
    tx_data[63:60] == 4'h0) else $error("raw10 pad");
  a_rgb666_pad: assert property (tx_type == CPK_T_RGB666 |->
    tx_data[63:54] == 10'h0) else $error("rgb666 pad");
  a_rgb888_pad: assert property (tx_type == CPK_T_RGB888 |->
    tx_data[63:48] == 16'h0) else $error("rgb888 pad");
  a_y422_pad: assert property (tx_type == CPK_T_Y422_10 |->
    tx_data[63:40] == 24'h0) else $error("yuv422 pad");
endmodule
bind cpk_packer cpk_monitor cpk_monitor_i (.clk, .rst, .pix_in, .sync_in,
  .tx_data, .tx_type, .tx_hsync, .tx_vsync, .tx_valid);

// *** dv/tb_top.sv ***
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top
  import cpk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0;
  logic        rst = 1;
  cpk_pixels_t pix_in = '0;
  cpk_sync_t   sync_in = '0;
  logic [5:0]  type_req = CPK_T_RAW8;
  logic [63:0] tx_data;
  logic [5:0]  tx_type;
  logic        tx_hsync, tx_vsync, tx_valid;
  logic [4:0]  width = '0;
  logic [3:0]  idx = '0;
  logic [23:0] field;
  int          checks = 0;
  int          fail_count = 0;
  always #20 clk = ~clk;
  cpk_packer cpk_packer_i (.clk, .rst, .pix_in, .sync_in, .type_req,
    .tx_data, .tx_type, .tx_hsync, .tx_vsync, .tx_valid);
  cpk_dev_model cpk_dev_model_i (.tx_data, .width, .idx, .field);
  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic load(logic [5:0] t);
    type_req = t;
    for (int i = 0; i < 10; i++) pix_in.pix[i] = 24'hA5C3E7 ^ (i * 24'h13579B);
    step(3);
  endtask
  task automatic check_word(int w, int n);
    for (int i = 0; i < n; i++) begin
      width = 5'(w);
      idx = 4'(i);
      #1;
      `CHK(field, pix_in.pix[i] & ((24'h1 << w) - 1))
    end
    `CHK(tx_data >> (w * n), 64'h0)
  endtask
  task automatic t_formats;
    logic [5:0] ty [18] = '{6'h28, 6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h20,
      6'h21, 6'h22, 6'h23, 6'h24, 6'h1E, 6'h1F, 6'h30, 6'h37, 6'h1A, 6'h18,
      6'h1C};
    int wd [18] = '{6, 7, 8, 10, 12, 14, 12, 15, 16, 18, 24, 8, 10, 8, 8, 8,
      8, 8};
    int nb [18] = '{10, 8, 8, 6, 5, 4, 4, 4, 4, 3, 2, 8, 4, 8, 8, 6, 8, 8};
    sync_in.valid = 1;
    for (int k = 0; k < 18; k++) begin
      load(ty[k]);
      `CHK(tx_type, ty[k])
      `CHK(tx_valid, 1'b1)
      check_word(wd[k], nb[k]);
    end
  endtask
  task automatic t_yuv420;
    load(CPK_T_Y420_10);
    sync_in.vsync = 1;
    step(1);
    `CHK(tx_vsync, 1'b1)
    sync_in.vsync = 0;
    step(1);
    `CHK(tx_vsync, 1'b0)
    for (int l = 0; l < 4; l++) begin
      sync_in.hsync = 1;
      step(2);
      check_word(10, (l % 2) ? 4 : 6);
      sync_in.hsync = 0;
      step(2);
    end
  endtask
  task automatic t_type_hold;
    load(CPK_T_RAW8);
    sync_in.hsync = 1;
    step(1);
    type_req = CPK_T_RAW6;
    step(3);
    `CHK(tx_type, CPK_T_RAW8)
    sync_in.hsync = 0;
    step(3);
    `CHK(tx_type, CPK_T_RAW6)
  endtask
  task automatic results;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    step(12);
    rst = 0;
    t_formats;
    t_yuv420;
    t_type_hold;
    results;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results;
  end
endmodule
